// [core/afsc_pkg.sv]
// package for the amplifier fault status and control register bank
package afsc_pkg;

   // ==========================================================================
   // register offsets
   localparam logic [7:0] OFS_CHAN_STATUS = 8'h70;
   localparam logic [7:0] OFS_GLOBAL_A    = 8'h71;
   localparam logic [7:0] OFS_GLOBAL_B    = 8'h72;
   localparam logic [7:0] OFS_OT_WARN     = 8'h73;
   localparam logic [7:0] OFS_REPORT_MASK = 8'h74;
   localparam logic [7:0] OFS_LATCH_CTRL  = 8'h75;
   localparam logic [7:0] OFS_MISC_CTRL   = 8'h76;
   localparam logic [7:0] OFS_CLEAR_CMD   = 8'h78;

   // ==========================================================================
   // reset values
   localparam logic [7:0] RST_REPORT_MASK = 8'h00;
   localparam logic [7:0] RST_LATCH_CTRL  = 8'hF8;
   localparam logic [7:0] RST_MISC_CTRL   = 8'h00;
   localparam logic [7:0] RD_UNMAPPED     = 8'h00;

   // ==========================================================================
   // field positions
   localparam int B_LEFT_DC        = 3;
   localparam int B_RIGHT_DC       = 2;
   localparam int B_LEFT_OC        = 1;
   localparam int B_RIGHT_OC       = 0;
   localparam int B_OTP_CRC        = 7;
   localparam int B_BQ_FAIL        = 6;
   localparam int B_CLK_FAULT      = 2;
   localparam int B_PS_OV          = 1;
   localparam int B_PS_UV          = 0;
   localparam int B_THERM_SD       = 0;
   localparam int B_THERM_WARN     = 2;
   localparam int B_MASK_TSD       = 7;
   localparam int B_MASK_LS_UV     = 6;
   localparam int B_MASK_LS_OV     = 5;
   localparam int B_MASK_CLK       = 4;
   localparam int B_MASK_PS_UV     = 3;
   localparam int B_MASK_PS_OV     = 2;
   localparam int B_DC_FAULT_REPORT_MASK        = 1;
   localparam int B_OVERCURRENT_REPORT_MASK        = 0;
   localparam int B_CLK_HOLD_EN    = 5;
   localparam int B_TSD_HOLD_EN    = 4;
   localparam int B_TW_HOLD_EN     = 3;
   localparam int B_TW_MASK        = 2;
   localparam int B_CLK_DET_HOLD   = 7;
   localparam int B_AUTO_RECOVER   = 4;
   localparam int B_ANALOG_CLEAR   = 7;
   localparam int FAULT_COUNT      = 12;

   // ==========================================================================
   // raw fault inputs from the detection circuits
   typedef struct packed {
      logic left_dc;
      logic right_dc;
      logic left_oc;
      logic right_oc;
      logic otp_crc_err;
      logic biquad_fail;
      logic clock_fault;
      logic ps_ov;
      logic ps_uv;
      logic ls_ov;
      logic ls_uv;
      logic therm_sd;
      logic therm_warn;
   } afsc_fault_t;

   // register bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } afsc_req_t;

endpackage : afsc_pkg

// [core/afsc_regs.sv]
// register bank for amplifier fault flags, report masks and latch controls
`timescale 1ns/1ps
// ==========================================================================
module afsc_regs
   import afsc_pkg::*;
#(
   parameter int DATA_W = 8
)(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire afsc_req_t   req,
   input  wire afsc_fault_t fault_raw,
   input  wire logic        clk_detect_raw,
   output logic [7:0]       rdata,
   output logic             rvalid,
   output logic             fault_report,
   output logic             clk_detect_status,
   output logic             auto_recovery_en,
   output logic             analog_clear_pulse
);

   // ==========================================================================
   // elaboration check
   if (DATA_W != 8)
   begin : g_bad_width
      $error("afsc_regs supports only 8-bit data");
   end

   // ==========================================================================
   // input synchronisers: detector levels arrive from the analog domain
   afsc_fault_t sync1_q;
   afsc_fault_t sync2_q;
   logic        det1_q;
   logic        det2_q;

   // two flops per bit, first stage read only by the second
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         det1_q  <= 1'b0;
         det2_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         sync1_q <= fault_raw;
         sync2_q <= sync1_q;
         det1_q  <= clk_detect_raw;
         det2_q  <= det1_q;
      end
   end

   // ==========================================================================
   // control registers
   logic [7:0] mask_q;
   logic [7:0] latch_ctrl_q;
   logic [7:0] misc_q;
   logic       clr_q;
   logic       wr_clear;

   assign wr_clear = req.wr && (req.addr == OFS_CLEAR_CMD) && req.wdata[B_ANALOG_CLEAR];

   // writable registers, reserved bits kept as storage
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mask_q       <= RST_REPORT_MASK;
         latch_ctrl_q <= RST_LATCH_CTRL;
         misc_q       <= RST_MISC_CTRL;
      end
      else if (clk_en && req.wr)
      begin
         if (req.addr == OFS_REPORT_MASK)
         begin
            mask_q <= req.wdata;
         end
         else if (req.addr == OFS_LATCH_CTRL)
         begin
            latch_ctrl_q <= req.wdata;
         end
         else if (req.addr == OFS_MISC_CTRL)
         begin
            misc_q <= req.wdata;
         end
      end
   end

   // write-only clear bit: one-cycle pulse, never stored for reads
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         clr_q <= 1'b0;
      end
      else if (clk_en)
      begin
         clr_q <= wr_clear;
      end
   end

   // ==========================================================================
   // fault flags: held flags are sticky until clear, set wins over clear
   logic [FAULT_COUNT-1:0] live;
   logic [FAULT_COUNT-1:0] hold_en;
   logic [FAULT_COUNT-1:0] flag_q;

   // order: ldc rdc loc roc crc bq clk ov uv tsd tw det
   assign live = {sync2_q.left_dc, sync2_q.right_dc, sync2_q.left_oc, sync2_q.right_oc,
                  sync2_q.otp_crc_err, sync2_q.biquad_fail, sync2_q.clock_fault,
                  sync2_q.ps_ov, sync2_q.ps_uv, sync2_q.therm_sd, sync2_q.therm_warn, det2_q};
   // channel and supply faults hold, clock, shutdown and warning when enabled; memory and biquad errors hold until cleared too
   assign hold_en = {4'hF, 2'h3, latch_ctrl_q[B_CLK_HOLD_EN],
                     2'h3, latch_ctrl_q[B_TSD_HOLD_EN],
                     latch_ctrl_q[B_TW_HOLD_EN], misc_q[B_CLK_DET_HOLD]};

   for (genvar i = 0; i < FAULT_COUNT; i++)
   begin : g_flag
      always_ff @(posedge clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            flag_q[i] <= 1'b0;
         end
         else if (clk_en)
         begin
            if (!hold_en[i])
            begin
               flag_q[i] <= live[i];
            end
            else if (live[i])
            begin
               flag_q[i] <= 1'b1;
            end
            else if (clr_q)
            begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================================
   // register images
   logic [7:0] chan_img;
   logic [7:0] glob_a_img;
   logic [7:0] glob_b_img;
   logic [7:0] warn_img;

   // reserved bits read zero
   always_comb
   begin
      chan_img   = 8'h00;
      glob_a_img = 8'h00;
      glob_b_img = 8'h00;
      warn_img   = 8'h00;
      chan_img[B_LEFT_DC]      = flag_q[11];
      chan_img[B_RIGHT_DC]     = flag_q[10];
      chan_img[B_LEFT_OC]      = flag_q[9];
      chan_img[B_RIGHT_OC]     = flag_q[8];
      glob_a_img[B_OTP_CRC]    = flag_q[7];
      glob_a_img[B_BQ_FAIL]    = flag_q[6];
      glob_a_img[B_CLK_FAULT]  = flag_q[5];
      glob_a_img[B_PS_OV]      = flag_q[4];
      glob_a_img[B_PS_UV]      = flag_q[3];
      glob_b_img[B_THERM_SD]   = flag_q[2];
      warn_img[B_THERM_WARN]   = flag_q[1];
   end

   // ==========================================================================
   // read port: one cycle after the request, unmapped and clear register read zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata  <= RD_UNMAPPED;
         rvalid <= 1'b0;
      end
      else if (clk_en)
      begin
         rvalid <= req.rd;
         if (!req.rd)
         begin
            rdata <= rdata;
         end
         else if (req.addr == OFS_CHAN_STATUS)
         begin
            rdata <= chan_img;
         end
         else if (req.addr == OFS_GLOBAL_A)
         begin
            rdata <= glob_a_img;
         end
         else if (req.addr == OFS_GLOBAL_B)
         begin
            rdata <= glob_b_img;
         end
         else if (req.addr == OFS_OT_WARN)
         begin
            rdata <= warn_img;
         end
         else if (req.addr == OFS_REPORT_MASK)
         begin
            rdata <= mask_q;
         end
         else if (req.addr == OFS_LATCH_CTRL)
         begin
            rdata <= latch_ctrl_q;
         end
         else if (req.addr == OFS_MISC_CTRL)
         begin
            rdata <= misc_q;
         end
         else
         begin
            rdata <= RD_UNMAPPED;
         end
      end
   end

   // ==========================================================================
   // fault report: unmasked flags other than memory, biquad and clock detect combine; logic supply faults use live levels
   logic report_d;

   always_comb
   begin
      report_d = ((flag_q[11] | flag_q[10]) & ~mask_q[B_DC_FAULT_REPORT_MASK])
               | ((flag_q[9] | flag_q[8]) & ~mask_q[B_OVERCURRENT_REPORT_MASK])
               | (flag_q[5] & ~mask_q[B_MASK_CLK])
               | (flag_q[4] & ~mask_q[B_MASK_PS_OV])
               | (flag_q[3] & ~mask_q[B_MASK_PS_UV])
               | (sync2_q.ls_ov & ~mask_q[B_MASK_LS_OV])
               | (sync2_q.ls_uv & ~mask_q[B_MASK_LS_UV])
               | (flag_q[2] & ~mask_q[B_MASK_TSD])
               | (flag_q[1] & ~latch_ctrl_q[B_TW_MASK]);
   end

   // registered side outputs
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_report       <= 1'b0;
         clk_detect_status  <= 1'b0;
         auto_recovery_en   <= 1'b0;
         analog_clear_pulse <= 1'b0;
      end
      else if (clk_en)
      begin
         fault_report       <= report_d;
         clk_detect_status  <= flag_q[0];
         auto_recovery_en   <= misc_q[B_AUTO_RECOVER];
         analog_clear_pulse <= clr_q;
      end
   end

   // ==========================================================================
   // assertions
   a_mask_reset: assert property (@(posedge clk) $rose(arst_n) |-> mask_q == 8'h00 && latch_ctrl_q == 8'hF8)
      else $error("control reset values wrong");
   a_clear_drops: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && clr_q && !live[5] && hold_en[5] |=> !flag_q[5])
      else $error("held clock fault not cleared");
   a_held_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[2] && hold_en[2] && !clr_q |=> flag_q[2])
      else $error("held shutdown flag dropped");
   a_unheld_tracks: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && !hold_en[1] |=> flag_q[1] == $past(live[1]))
      else $error("unheld warning not tracking");
   a_warn_masked: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && latch_ctrl_q[B_TW_MASK] && flag_q[1] && !(|flag_q[11:2]) && !sync2_q.ls_ov && !sync2_q.ls_uv
      |=> !fault_report)
      else $error("masked warning reported");
   a_dc_report: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[11] && !mask_q[B_DC_FAULT_REPORT_MASK] |=> fault_report)
      else $error("dc fault not reported");
   a_chan_read: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && req.rd && req.addr == OFS_CHAN_STATUS |=> rvalid && rdata[7:4] == 4'h0)
      else $error("channel read wrong");
   a_glob_b_read: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && req.rd && req.addr == OFS_GLOBAL_B |=> rdata == {7'h00, $past(flag_q[2])})
      else $error("global b read wrong");
   a_auto_rec: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && $past(clk_en) |-> auto_recovery_en == $past(misc_q[B_AUTO_RECOVER]))
      else $error("auto recovery output stale");
   // held and unheld faults, mask write, reports, clear pulse and read images; a lost hold here means a fault the host never sees
   a_crc_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[7] && !clr_q |=> flag_q[7])
      else $error("memory check flag dropped without clear");
   a_bq_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[6] && !clr_q |=> flag_q[6])
      else $error("biquad flag dropped without clear");
   a_clk_held: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[5] && latch_ctrl_q[B_CLK_HOLD_EN] && !clr_q |=> flag_q[5])
      else $error("held clock fault dropped");
   a_tw_held: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[1] && latch_ctrl_q[B_TW_HOLD_EN] && !clr_q |=> flag_q[1])
      else $error("held warning dropped");
   a_unheld_shutdown: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && !latch_ctrl_q[B_TSD_HOLD_EN] |=> flag_q[2] == $past(live[2]))
      else $error("unheld shutdown not tracking");
   a_det_live: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && !misc_q[B_CLK_DET_HOLD] |=> flag_q[0] == $past(det2_q))
      else $error("clock detect not following live result");
   a_mask_write: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && req.wr && req.addr == OFS_REPORT_MASK |=> mask_q == $past(req.wdata))
      else $error("mask write lost");
   a_oc_report: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[9] && !mask_q[B_OVERCURRENT_REPORT_MASK] |=> fault_report)
      else $error("over-current fault not reported");
   a_tsd_report: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && flag_q[2] && !mask_q[B_MASK_TSD] |=> fault_report)
      else $error("shutdown fault not reported");
   a_clear_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && clr_q |=> analog_clear_pulse)
      else $error("clear pulse missing");
   a_glob_a_read: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && req.rd && req.addr == OFS_GLOBAL_A |=> rvalid && rdata[5:3] == 3'h0)
      else $error("global a reserved bits not zero");
   a_warn_read: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && req.rd && req.addr == OFS_OT_WARN |=> rdata == {5'h00, $past(flag_q[1]), 2'h0})
      else $error("warning read wrong");
   c_clear_cmd: cover property (@(posedge clk) disable iff (!arst_n) wr_clear ##2 analog_clear_pulse);
   c_report: cover property (@(posedge clk) disable iff (!arst_n) $rose(fault_report));
   c_det_hold: cover property (@(posedge clk) disable iff (!arst_n) misc_q[B_CLK_DET_HOLD] && flag_q[0] && !det2_q);

endmodule : afsc_regs

// [sim/afsc_host_model.sv]
// host controller model that drives the register request port
`timescale 1ns/1ps
module afsc_host_model
   import afsc_pkg::*;
(
   input  wire logic       clk,
   output afsc_req_t       req,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid
);
   // ==========================================================================
   // bus cycles
   // idle at time zero so nothing is taken before the first request
   initial req = '0;

   // write: request stands for exactly one taking edge, then released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask : wr

   // read: answer launched at the taking edge stands one cycle, so sample just after that edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      d = rdata;
      v = rvalid;
   endtask : rd

   // analog fault clear: only bit 7 set, other bits left at zero
   task automatic clear();
      wr(OFS_CLEAR_CMD, 8'h80);
   endtask : clear
endmodule : afsc_host_model

// [sim/afsc_regs_tb_top.sv]
// self-checking bench for the fault status and control register bank
`timescale 1ns/1ps
module afsc_regs_tb_top
   import afsc_pkg::*;
;
   logic        clk;
   logic        arst_n;
   logic        clk_en;
   afsc_req_t   req;
   afsc_fault_t fault_raw;
   logic        clk_detect_raw;
   logic [7:0]  rdata;
   logic        rvalid;
   logic        fault_report;
   logic        clk_detect_status;
   logic        auto_recovery_en;
   logic        analog_clear_pulse;
   int          miscompares;
   int          checks_done;
   // fault index i drives fault_raw bit 12-i; logic supply faults have no register
   logic [7:0]  f_adr [13] = '{8'h70, 8'h70, 8'h70, 8'h70, 8'h71, 8'h71, 8'h71, 8'h71, 8'h71,
                               8'h77, 8'h77, 8'h72, 8'h73};
   logic [7:0]  f_val [13] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h80, 8'h40, 8'h04, 8'h02, 8'h01,
                               8'h00, 8'h00, 8'h01, 8'h04};
   // mask register, mask value and the fault index it hides
   logic [7:0]  m_adr [9] = '{8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h74, 8'h75};
   logic [7:0]  m_val [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hFC};
   int          m_idx [9] = '{2, 0, 7, 8, 6, 9, 10, 11, 12};
   int          u_idx [3] = '{6, 11, 12};

   // ==========================================================================
   // clock, design and host
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   afsc_regs #(.DATA_W(8)) i_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .req(req),
      .fault_raw(fault_raw), .clk_detect_raw(clk_detect_raw), .rdata(rdata), .rvalid(rvalid),
      .fault_report(fault_report), .clk_detect_status(clk_detect_status),
      .auto_recovery_en(auto_recovery_en), .analog_clear_pulse(analog_clear_pulse));

   afsc_host_model i_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

   // ==========================================================================
   // compare and helper tasks
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic g, input logic e);
      chk_byte({7'h00, g}, {7'h00, e});
   endtask : chk_bit

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      i_host.rd(a, d, v);
      chk_bit(v, 1'b1);
      chk_byte(d, e);
   endtask : rd_chk

   // six edges cover the two sync stages, the flag and the report register
   task automatic set_fault(input logic [12:0] f);
      @(posedge clk);
      fault_raw <= afsc_fault_t'(f);
      repeat (6) @(posedge clk);
      #1;
   endtask : set_fault

   task automatic drv_det(input logic v);
      @(posedge clk);
      clk_detect_raw <= v;
      repeat (6) @(posedge clk);
      #1;
   endtask : drv_det

   // clear command must give exactly one pulse
   task automatic clear_chk();
      int n;
      n = 0;
      i_host.clear();
      repeat (4)
      begin
         @(posedge clk);
         #1;
         if (analog_clear_pulse === 1'b1)
            n++;
      end
      chk_byte(n[7:0], 8'h01);
   endtask : clear_chk

   task automatic finish_test();
      if (miscompares == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // ==========================================================================
   // watchdog: whole sequence needs well under 5000 cycles
   initial
   begin
      #200000;
      miscompares++;
      finish_test();
   end

   // ==========================================================================
   // test sequence
   initial
   begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      fault_raw = '0;
      clk_detect_raw = 1'b0;
      miscompares = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk_bit(fault_report, 1'b0);
      chk_bit(auto_recovery_en, 1'b0);
      for (int a = 8'h70; a <= 8'h78; a++)
         rd_chk(a[7:0], (a == 8'h75) ? 8'hF8 : 8'h00);
      // read-only status ignores writes; control registers store every bit
      for (int a = 8'h70; a <= 8'h76; a++)
      begin
         i_host.wr(a[7:0], 8'hFF);
         rd_chk(a[7:0], (a >= 8'h74) ? 8'hFF : 8'h00);
      end
      chk_bit(auto_recovery_en, 1'b1);
      i_host.wr(OFS_REPORT_MASK, 8'h00);
      i_host.wr(OFS_LATCH_CTRL, 8'hF8);
      i_host.wr(OFS_MISC_CTRL, 8'h00);
      // register lands at the taking edge, the output one edge later
      repeat (2) @(posedge clk);
      #1;
      chk_bit(auto_recovery_en, 1'b0);
      // frozen clock enable drops the request
      @(posedge clk);
      clk_en <= 1'b0;
      i_host.wr(OFS_REPORT_MASK, 8'hFF);
      clk_en <= 1'b1;
      rd_chk(OFS_REPORT_MASK, 8'h00);
      // each fault: reported except memory and biquad errors, held after it goes except logic supply faults, gone after clear
      for (int i = 0; i < 13; i++)
      begin
         set_fault(13'h0001 << (12 - i));
         if (i != 4 && i != 5)
            chk_bit(fault_report, 1'b1);
         rd_chk(f_adr[i], f_val[i]);
         set_fault(13'h0000);
         if (i != 4 && i != 5)
            chk_bit(fault_report, f_val[i] != 8'h00);
         rd_chk(f_adr[i], f_val[i]);
         clear_chk();
         rd_chk(f_adr[i], 8'h00);
         chk_bit(fault_report, 1'b0);
      end
      // each mask hides only the report, unmasking shows the fault again
      for (int k = 0; k < 9; k++)
      begin
         i_host.wr(m_adr[k], m_val[k]);
         set_fault(13'h0001 << (12 - m_idx[k]));
         chk_bit(fault_report, 1'b0);
         i_host.wr(OFS_REPORT_MASK, 8'h00);
         i_host.wr(OFS_LATCH_CTRL, 8'hF8);
         repeat (3) @(posedge clk);
         #1;
         chk_bit(fault_report, 1'b1);
         set_fault(13'h0000);
         clear_chk();
      end
      // hold enables off: clock, shutdown and warning flags track the fault
      i_host.wr(OFS_LATCH_CTRL, 8'hC0);
      for (int j = 0; j < 3; j++)
      begin
         set_fault(13'h0001 << (12 - u_idx[j]));
         rd_chk(f_adr[u_idx[j]], f_val[u_idx[j]]);
         set_fault(13'h0000);
         rd_chk(f_adr[u_idx[j]], 8'h00);
      end
      i_host.wr(OFS_LATCH_CTRL, 8'hF8);
      // clock detect status: live, then held until clear
      for (int h = 0; h < 2; h++)
      begin
         i_host.wr(OFS_MISC_CTRL, (h == 1) ? 8'h80 : 8'h00);
         drv_det(1'b1);
         chk_bit(clk_detect_status, 1'b1);
         drv_det(1'b0);
         chk_bit(clk_detect_status, h == 1);
      end
      clear_chk();
      chk_bit(clk_detect_status, 1'b0);
      finish_test();
   end
endmodule : afsc_regs_tb_top
